// ===== assc_pkg.sv
package assc_pkg;

	// Step register indices and the byte addresses derived from them.
	localparam logic [7:0] STEP5_IDX = 8'h95;
	localparam logic [7:0] STEP6_IDX = 8'h96;
	localparam logic [11:0] STEP5_ADDR = {2'h0, STEP5_IDX, 2'h0};
	localparam logic [11:0] STEP6_ADDR = {2'h0, STEP6_IDX, 2'h0};
	localparam logic [11:0] CTRL_ADDR = 12'h300;
	localparam logic [11:0] STATUS_ADDR = 12'h304;

	// Field positions inside a step configuration word.
	localparam int EN_BIT = 15;
	localparam int GAIN_HI = 14;
	localparam int GAIN_LO = 13;
	localparam int RSV_HI = 12;
	localparam int RSV_LO = 5;
	localparam int NEG_BIT = 4;
	localparam int POS_HI = 3;
	localparam int CTRL_RUN_BIT = 0;

	// Reset values and the mask of writable bits.
	localparam logic [15:0] STEP5_RST = 16'h0005;
	localparam logic [15:0] STEP6_RST = 16'h0006;
	localparam logic [15:0] WR_MASK = 16'hE01F;
	localparam logic RUN_RST = 1'h0;

	// Gain codes and the factors they give.
	localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
	localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
	localparam logic [2:0] GAIN_X1 = 3'h1;
	localparam logic [2:0] GAIN_X2 = 3'h2;
	localparam logic [2:0] GAIN_X4 = 3'h4;

	// Positive codes at or above this value pick an internal source.
	localparam logic [3:0] POS_AUTO_MIN = 4'h8;

	// Negative input routing codes.
	localparam logic [1:0] NEG_AGND = 2'h0;
	localparam logic [1:0] NEG_EXT7 = 2'h1;
	localparam logic [1:0] NEG_AUTO = 2'h2;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register selection and sequencer states.
	typedef enum logic [2:0] {SEL_NONE, SEL_STEP5, SEL_STEP6, SEL_CTRL, SEL_STATUS} assc_sel_t;
	typedef enum logic {SEQ_IDLE, SEQ_RUN} assc_seq_state_t;

endpackage

// ===== assc_decode.sv
`timescale 1ns/1ps

// Turns one step configuration word into converter selections.
module assc_decode (
	// Stored configuration word.
	input wire logic [15:0] cfg,
	// Decoded selections.
	output logic enable,
	output logic [2:0] gain_factor,
	output logic [3:0] pos_sel,
	output logic [1:0] neg_route
);

	// Gain, positive and negative decoding; internal sources force the negative input.
	always_comb begin
		enable = cfg[assc_pkg::EN_BIT];
		case (cfg[assc_pkg::GAIN_HI:assc_pkg::GAIN_LO])
			assc_pkg::GAIN_CODE_X1: gain_factor = assc_pkg::GAIN_X1;
			assc_pkg::GAIN_CODE_X2: gain_factor = assc_pkg::GAIN_X2;
			default: gain_factor = assc_pkg::GAIN_X4;
		endcase
		pos_sel = cfg[assc_pkg::POS_HI:0];
		if (pos_sel >= assc_pkg::POS_AUTO_MIN) begin
			neg_route = assc_pkg::NEG_AUTO;
		end else if (cfg[assc_pkg::NEG_BIT]) begin
			neg_route = assc_pkg::NEG_EXT7;
		end else begin
			neg_route = assc_pkg::NEG_AGND;
		end
	end

endmodule

// ===== assc_seq.sv
`timescale 1ns/1ps

// Walks the enabled steps, skipping any that are disabled.
module assc_seq (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Control.
	input wire logic run,
	input wire logic [1:0] step_en,
	input wire logic advance,
	// State.
	output logic active,
	output logic cur_step
);

	assc_pkg::assc_seq_state_t state_reg;
	assc_pkg::assc_seq_state_t state_next;
	logic step_reg;
	logic step_next;

	// Next state: start on the first enabled step, move on to the next enabled one.
	always_comb begin
		state_next = state_reg;
		step_next = step_reg;
		case (state_reg)
			assc_pkg::SEQ_IDLE: begin
				if (run && (|step_en)) begin
					state_next = assc_pkg::SEQ_RUN;
					step_next = step_en[0] ? 1'b0 : 1'b1;
				end
			end
			assc_pkg::SEQ_RUN: begin
				if (!run || !(|step_en)) begin
					state_next = assc_pkg::SEQ_IDLE;
				end else if (advance || !step_en[step_reg]) begin
					step_next = step_en[~step_reg] ? ~step_reg : step_reg;
				end
			end
			default: begin
				state_next = assc_pkg::SEQ_IDLE;
			end
		endcase
	end

	// State registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= assc_pkg::SEQ_IDLE;
			step_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			step_reg <= step_next;
		end
	end

	// Outputs come straight from the state registers.
	assign active = (state_reg == assc_pkg::SEQ_RUN);
	assign cur_step = step_reg;

endmodule

// ===== assc_top.sv
`timescale 1ns/1ps

module assc_top #(
	parameter int ADDR_W = 12
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel.
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// Write data channel.
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// Write response channel.
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read address channel.
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// Read data channel.
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Converter side.
	input wire logic step_advance,
	output logic conv_valid,
	output logic conv_step,
	output logic [2:0] conv_gain,
	output logic [3:0] conv_pos,
	output logic [1:0] conv_neg
);

	// The decoder compares address bits 11:2 only.
	if (ADDR_W < 12) begin : g_addr_check
		$error("ADDR_W must be at least 12");
	end

	// Stored configuration, one word per step; index 0 is step five.
	logic [15:0] cfg_reg [2];
	logic [15:0] cfg_next [2];
	logic run_reg;
	logic run_next;

	// Write path state.
	logic [11:0] aw_addr_reg;
	logic [11:0] aw_addr_next;
	logic aw_have_reg;
	logic aw_have_next;
	logic [15:0] w_data_reg;
	logic [15:0] w_data_next;
	logic [1:0] w_strb_reg;
	logic [1:0] w_strb_next;
	logic w_have_reg;
	logic w_have_next;
	logic bvalid_reg;
	logic bvalid_next;
	logic [1:0] bresp_reg;
	logic [1:0] bresp_next;

	// Read path state.
	logic rvalid_reg;
	logic rvalid_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0] rresp_reg;
	logic [1:0] rresp_next;

	// Converter selection registers.
	logic conv_valid_reg;
	logic conv_valid_next;
	logic conv_step_reg;
	logic conv_step_next;
	logic [2:0] conv_gain_reg;
	logic [2:0] conv_gain_next;
	logic [3:0] conv_pos_reg;
	logic [3:0] conv_pos_next;
	logic [1:0] conv_neg_reg;
	logic [1:0] conv_neg_next;

	// Decoded step fields and sequencer state.
	logic [1:0] dec_en;
	logic [2:0] dec_gain [2];
	logic [3:0] dec_pos [2];
	logic [1:0] dec_neg [2];
	logic seq_active;
	logic seq_cur;
	logic [15:0] sel_cfg;
	logic do_write;
	assc_pkg::assc_sel_t wr_sel;
	assc_pkg::assc_sel_t rd_sel;

	// Maps a byte address to the register it names; upper address bits alias.
	function automatic assc_pkg::assc_sel_t addr_sel(input logic [11:0] a);
		assc_pkg::assc_sel_t s;
		s = assc_pkg::SEL_NONE;
		if (a[11:2] == assc_pkg::STEP5_ADDR[11:2]) begin
			s = assc_pkg::SEL_STEP5;
		end else if (a[11:2] == assc_pkg::STEP6_ADDR[11:2]) begin
			s = assc_pkg::SEL_STEP6;
		end else if (a[11:2] == assc_pkg::CTRL_ADDR[11:2]) begin
			s = assc_pkg::SEL_CTRL;
		end else if (a[11:2] == assc_pkg::STATUS_ADDR[11:2]) begin
			s = assc_pkg::SEL_STATUS;
		end
		return s;
	endfunction

	// One decoder per step.
	for (genvar g = 0; g < 2; g++) begin : g_dec
		assc_decode u_dec (
			.cfg(cfg_reg[g]),
			.enable(dec_en[g]),
			.gain_factor(dec_gain[g]),
			.pos_sel(dec_pos[g]),
			.neg_route(dec_neg[g])
		);
	end

	// Sequencer over the two steps.
	assc_seq u_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(run_reg),
		.step_en(dec_en),
		.advance(step_advance),
		.active(seq_active),
		.cur_step(seq_cur)
	);

	// Handshake outputs: each address or data slot accepts while empty.
	assign awready = !aw_have_reg;
	assign wready = !w_have_reg;
	assign arready = !rvalid_reg;
	assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
	assign wr_sel = addr_sel(aw_addr_reg);
	assign rd_sel = addr_sel(araddr[11:0]);
	assign sel_cfg = cfg_reg[seq_cur];

	// Write path: latch address and data in either order, then commit both.
	always_comb begin
		logic [15:0] merged;
		merged = 16'h0000;
		aw_addr_next = aw_addr_reg;
		aw_have_next = aw_have_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		cfg_next[0] = cfg_reg[0];
		cfg_next[1] = cfg_reg[1];
		run_next = run_reg;
		if (awvalid && awready) begin
			aw_addr_next = awaddr[11:0];
			aw_have_next = 1'b1;
		end
		if (wvalid && wready) begin
			w_data_next = wdata[15:0];
			w_strb_next = wstrb[1:0];
		end
		if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
		if (do_write) begin
			aw_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = assc_pkg::RESP_OKAY;
			case (wr_sel)
				assc_pkg::SEL_STEP5, assc_pkg::SEL_STEP6: begin
					merged = cfg_reg[wr_sel == assc_pkg::SEL_STEP6];
					if (w_strb_reg[0]) begin
						merged[7:0] = w_data_reg[7:0];
					end
					if (w_strb_reg[1]) begin
						merged[15:8] = w_data_reg[15:8];
					end
					cfg_next[wr_sel == assc_pkg::SEL_STEP6] = merged & assc_pkg::WR_MASK;
				end
				assc_pkg::SEL_CTRL: begin
					if (w_strb_reg[0]) begin
						run_next = w_data_reg[assc_pkg::CTRL_RUN_BIT];
					end
				end
				assc_pkg::SEL_STATUS: begin
					bresp_next = assc_pkg::RESP_OKAY;
				end
				default: begin
					bresp_next = assc_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// The data slot clears on commit and fills on a data handshake.
	always_comb begin
		w_have_next = w_have_reg;
		if (do_write) begin
			w_have_next = 1'b0;
		end
		if (wvalid && wready) begin
			w_have_next = 1'b1;
		end
	end

	// Write path registers; step registers take their documented reset words.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_reg <= 12'h000;
			aw_have_reg <= 1'b0;
			w_data_reg <= 16'h0000;
			w_strb_reg <= 2'h0;
			w_have_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= assc_pkg::RESP_OKAY;
			cfg_reg[0] <= assc_pkg::STEP5_RST;
			cfg_reg[1] <= assc_pkg::STEP6_RST;
			run_reg <= assc_pkg::RUN_RST;
		end else begin
			aw_addr_reg <= aw_addr_next;
			aw_have_reg <= aw_have_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			w_have_reg <= w_have_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			cfg_reg[0] <= cfg_next[0];
			cfg_reg[1] <= cfg_next[1];
			run_reg <= run_next;
		end
	end

	// Read path: answer one cycle after the address is taken.
	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rvalid_reg && rready) begin
			rvalid_next = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_next = 1'b1;
			rresp_next = assc_pkg::RESP_OKAY;
			case (rd_sel)
				assc_pkg::SEL_STEP5: rdata_next = {16'h0000, cfg_reg[0] & assc_pkg::WR_MASK};
				assc_pkg::SEL_STEP6: rdata_next = {16'h0000, cfg_reg[1] & assc_pkg::WR_MASK};
				assc_pkg::SEL_CTRL: rdata_next = {31'h00000000, run_reg};
				assc_pkg::SEL_STATUS: rdata_next = {30'h00000000, seq_cur, seq_active};
				default: begin
					rdata_next = 32'h00000000;
					rresp_next = assc_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// Read path registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= assc_pkg::RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// Converter selections except conv_step follow the current step only while it is enabled; conv_step always follows it.
	always_comb begin
		conv_valid_next = seq_active && dec_en[seq_cur];
		conv_step_next = seq_cur;
		conv_gain_next = 3'h0;
		conv_pos_next = 4'h0;
		conv_neg_next = assc_pkg::NEG_AGND;
		if (conv_valid_next) begin
			conv_gain_next = dec_gain[seq_cur];
			conv_pos_next = dec_pos[seq_cur];
			conv_neg_next = dec_neg[seq_cur];
		end
	end

	// Converter selection registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_valid_reg <= 1'b0;
			conv_step_reg <= 1'b0;
			conv_gain_reg <= 3'h0;
			conv_pos_reg <= 4'h0;
			conv_neg_reg <= assc_pkg::NEG_AGND;
		end else begin
			conv_valid_reg <= conv_valid_next;
			conv_step_reg <= conv_step_next;
			conv_gain_reg <= conv_gain_next;
			conv_pos_reg <= conv_pos_next;
			conv_neg_reg <= conv_neg_next;
		end
	end

	// Output drivers.
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign conv_valid = conv_valid_reg;
	assign conv_step = conv_step_reg;
	assign conv_gain = conv_gain_reg;
	assign conv_pos = conv_pos_reg;
	assign conv_neg = conv_neg_reg;

	// Checks on the register bank and the selections it drives.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_ready;
		aw_have_reg && w_have_reg && !bvalid_reg;
	endsequence

	sequence s_wr_step6;
		s_wr_ready ##0 (wr_sel == assc_pkg::SEL_STEP6);
	endsequence

	chk_reset_step6:
	assert property ($rose(aresetn) |-> cfg_reg[1] == assc_pkg::STEP6_RST) else $error("step six reset word wrong");
	chk_reset_step5:
	assert property ($rose(aresetn) |-> cfg_reg[0] == assc_pkg::STEP5_RST) else $error("step five reset word wrong");
	chk_reserved_zero:
	assert property (s_wr_step6 |=> bvalid && cfg_reg[1][assc_pkg::RSV_HI:assc_pkg::RSV_LO] == 8'h00)
		else $error("reserved bits stored");
	chk_read_reserved:
	assert property ((arvalid && arready && rd_sel == assc_pkg::SEL_STEP5) |=> rvalid && rdata[12:5] == 8'h00)
		else $error("reserved bits read nonzero");
	chk_enable_gate:
	assert property (!sel_cfg[assc_pkg::EN_BIT] |=> !conv_valid) else $error("disabled step selected");
	chk_gain_map:
	assert property (conv_valid |-> conv_gain == (($past(sel_cfg[14:13]) == 2'h0) ? 3'h1 :
		($past(sel_cfg[14:13]) == 2'h1) ? 3'h2 : 3'h4)) else $error("gain mapping wrong");
	chk_neg_manual:
	assert property ((conv_valid && !conv_pos[3]) |-> conv_neg == ($past(sel_cfg[4]) ? 2'h1 : 2'h0))
		else $error("negative routing wrong");
	chk_pos_route:
	assert property (conv_valid |-> conv_pos == $past(sel_cfg[3:0])) else $error("positive select wrong");
	chk_auto_neg:
	assert property ((conv_valid && conv_pos[3]) |-> conv_neg == assc_pkg::NEG_AUTO)
		else $error("automatic negative not applied");
	chk_skip_off:
	assert property ((seq_active && run_reg && dec_en == 2'h1 && step_advance) |=> !seq_cur)
		else $error("disabled step not skipped");

endmodule

// ===== assc_top_bench.sv
`timescale 1ns/1ps

// Self-checking bench for the step configuration bank and the converter selections it drives.
module assc_top_bench;
	typedef struct {
		logic [15:0] cfg;
		logic [2:0] gain;
		logic [3:0] pos;
		logic [1:0] neg;
	} assc_row_t;

	logic aclk, aresetn;
	logic [11:0] awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd_data;
	logic [3:0] wstrb, k;
	logic [1:0] bresp, rresp, conv_neg, resp;
	logic step_advance, conv_valid, conv_step;
	logic [2:0] conv_gain;
	logic [3:0] conv_pos;
	int error_cnt = 0;
	int n_checks = 0;
	assc_row_t rows [16];

	// Device under test.
	assc_top #(.ADDR_W(12)) i_assc_top (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.step_advance(step_advance), .conv_valid(conv_valid), .conv_step(conv_step),
		.conv_gain(conv_gain), .conv_pos(conv_pos), .conv_neg(conv_neg));

	// Clock of 50 ns period.
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// Compares one value and counts the outcome.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Writes one word and returns the response; address and data are held until each is taken.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int t;
		t = 0;
		r = 2'h3;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (t < 50) begin
			@(posedge aclk);
			t++;
			if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				t = 100;
			end
		end
		check(t, 100);
	endtask

	// Reads one word; the address is held until it is taken.
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		t = 0;
		araddr <= a;
		arvalid <= 1'b1;
		while (t < 50) begin
			@(posedge aclk);
			t++;
			if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				t = 100;
			end
		end
		check(t, 100);
	endtask

	// Reads and compares both data and response.
	task automatic rdchk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		rd(a, rd_data, resp);
		check(rd_data, ed);
		check({30'h0, resp}, {30'h0, er});
	endtask

	// Lets register and sequencer updates reach the converter outputs.
	task automatic settle();
		repeat (4) @(posedge aclk);
	endtask

	// Compares all converter selections at once.
	task automatic convchk(input logic s, input logic [2:0] g, input logic [3:0] p, input logic [1:0] n);
		check({21'h0, conv_valid, conv_step, conv_gain, conv_pos, conv_neg}, {21'h0, 1'b1, s, g, p, n});
	endtask

	// One pulse of the converter engine moves the sequence on.
	task automatic advance();
		step_advance <= 1'b1;
		@(posedge aclk);
		step_advance <= 1'b0;
		settle();
	endtask

	// Prints one line as each test ends.
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog cuts a hang short well beyond the few hundred cycles the tests take.
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		results();
	end

	// Main sequence: reset, table of configurations, then the awkward cases.
	initial begin
		{aresetn, awaddr, araddr, awprot, arprot, awvalid, wvalid, arvalid, wdata, step_advance} = '0;
		{bready, rready, wstrb} = 6'h3F;
		for (int i = 0; i < 16; i++) begin
			k = i[3:0];
			rows[i].cfg = {1'b1, k[1:0], 8'h00, k[2], k};
			rows[i].gain = (k[1:0] == 2'h0) ? assc_pkg::GAIN_X1 : (k[1:0] == 2'h1) ? assc_pkg::GAIN_X2 : assc_pkg::GAIN_X4;
			rows[i].pos = k;
			rows[i].neg = k[3] ? assc_pkg::NEG_AUTO : (k[2] ? assc_pkg::NEG_EXT7 : assc_pkg::NEG_AGND);
		end
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check({29'h0, awready, wready, arready}, 32'h0000_0007);
		rdchk(assc_pkg::STEP5_ADDR, 32'h0000_0005, assc_pkg::RESP_OKAY);
		rdchk(assc_pkg::STEP6_ADDR, 32'h0000_0006, assc_pkg::RESP_OKAY);
		check({31'h0, conv_valid}, 32'h0);
		done("reset values");
		// Every gain code, every positive code and both negative bits on step five.
		wr(assc_pkg::CTRL_ADDR, 32'h0000_0001, resp);
		rdchk(assc_pkg::CTRL_ADDR, 32'h0000_0001, assc_pkg::RESP_OKAY);
		for (int i = 0; i < 16; i++) begin
			wr(assc_pkg::STEP5_ADDR, {16'h0, rows[i].cfg}, resp);
			settle();
			convchk(1'b0, rows[i].gain, rows[i].pos, rows[i].neg);
			rdchk(assc_pkg::STEP5_ADDR, {16'h0, rows[i].cfg}, assc_pkg::RESP_OKAY);
		end
		done("configuration table");
		// Both steps enabled: advance alternates between them.
		wr(assc_pkg::STEP6_ADDR, 32'h0000_A013, resp);
		check({30'h0, resp}, {30'h0, assc_pkg::RESP_OKAY});
		advance();
		convchk(1'b1, assc_pkg::GAIN_X2, 4'h3, assc_pkg::NEG_EXT7);
		rdchk(assc_pkg::STATUS_ADDR, 32'h0000_0003, assc_pkg::RESP_OKAY);
		advance();
		convchk(1'b0, assc_pkg::GAIN_X4, 4'hF, assc_pkg::NEG_AUTO);
		done("alternating steps");
		// Disabling the current step moves to the other; advance then stays.
		wr(assc_pkg::STEP5_ADDR, 32'h0000_7FFF, resp);
		settle();
		convchk(1'b1, assc_pkg::GAIN_X2, 4'h3, assc_pkg::NEG_EXT7);
		rdchk(assc_pkg::STEP5_ADDR, 32'h0000_601F, assc_pkg::RESP_OKAY);
		advance();
		convchk(1'b1, assc_pkg::GAIN_X2, 4'h3, assc_pkg::NEG_EXT7);
		done("skip disabled step");
		// All ones on step six: reserved bits drop, automatic negative wins.
		wr(assc_pkg::STEP6_ADDR, 32'hFFFF_FFFF, resp);
		rdchk(assc_pkg::STEP6_ADDR, 32'h0000_E01F, assc_pkg::RESP_OKAY);
		settle();
		convchk(1'b1, assc_pkg::GAIN_X4, 4'hF, assc_pkg::NEG_AUTO);
		wr(assc_pkg::STEP6_ADDR, 32'h0000_0006, resp);
		settle();
		check({31'h0, conv_valid}, 32'h0);
		done("reserved bits and no step enabled");
		// Unmapped address is refused and leaves the bank alone.
		wr(12'h100, 32'h0000_FFFF, resp);
		check({30'h0, resp}, {30'h0, assc_pkg::RESP_SLVERR});
		rdchk(12'h100, 32'h0, assc_pkg::RESP_SLVERR);
		rdchk(assc_pkg::STEP6_ADDR, 32'h0000_0006, assc_pkg::RESP_OKAY);
		// A status write is answered but changes nothing: idle, last step six.
		wr(assc_pkg::STATUS_ADDR, 32'h0000_FFFF, resp);
		check({30'h0, resp}, {30'h0, assc_pkg::RESP_OKAY});
		rdchk(assc_pkg::STATUS_ADDR, 32'h0000_0002, assc_pkg::RESP_OKAY);
		done("unmapped address");
		// A second reset while a step is running restores the reset values.
		wr(assc_pkg::STEP5_ADDR, 32'h0000_8001, resp);
		settle();
		convchk(1'b0, assc_pkg::GAIN_X1, 4'h1, assc_pkg::NEG_AGND);
		// Only step five enabled: an advance must stay on step five.
		advance();
		convchk(1'b0, assc_pkg::GAIN_X1, 4'h1, assc_pkg::NEG_AGND);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check({31'h0, conv_valid}, 32'h0);
		rdchk(assc_pkg::STEP5_ADDR, 32'h0000_0005, assc_pkg::RESP_OKAY);
		rdchk(assc_pkg::STEP6_ADDR, 32'h0000_0006, assc_pkg::RESP_OKAY);
		done("reset in mid-run");
		results();
	end
endmodule
